// ==== src/low_power_mode_controller.v ====
// Purpose: Low-power mode sequencing, regulator and clock selection control
// Assumes: All asynchronous inputs are synchronised here; wake sources are levels
// Notes:   Register map is reached over AXI4-Lite
`include "lpm_ctrl_defines.vh"

module low_power_mode_controller (
  input  wire                sys_clk_i,          // System clock, 100 MHz
  input  wire                rst_n_i,            // Synchronous reset, active low
  input  wire                supply_ok_i,        // Supply above reset threshold
  input  wire                monitor_above_i,    // Supply above monitor threshold
  input  wire                sleep_req_i,        // Core wait-for-interrupt, pulse
  input  wire                irq_any_i,          // Any pending interrupt
  input  wire [`EVT_W-1:0]   event_lines_i,      // 16 I/O, monitor, alarm, net, USB
  input  wire                external_reset_pin_n_i, // Reset pin, active low
  input  wire                watchdog_reset_i,   // Independent watchdog reset
  input  wire                wakeup_pin_i,       // Standby wake-up pin
  input  wire                ext_clk_fail_i,     // External clock failure detect
  input  wire                int_osc_ready_i,    // Internal oscillator stable
  input  wire [3:0]          s_axi_awaddr,       // Write address
  input  wire                s_axi_awvalid,      // Write address valid
  output wire                s_axi_awready,      // Write address ready
  input  wire [31:0]         s_axi_wdata,        // Write data
  input  wire [3:0]          s_axi_wstrb,        // Write strobes
  input  wire                s_axi_wvalid,       // Write data valid
  output wire                s_axi_wready,       // Write data ready
  output reg  [1:0]          s_axi_bresp,        // Write response
  output reg                 s_axi_bvalid,       // Write response valid
  input  wire                s_axi_bready,       // Write response ready
  input  wire [3:0]          s_axi_araddr,       // Read address
  input  wire                s_axi_arvalid,      // Read address valid
  output wire                s_axi_arready,      // Read address ready
  output reg  [31:0]         s_axi_rdata,        // Read data
  output reg  [1:0]          s_axi_rresp,        // Read response
  output reg                 s_axi_rvalid,       // Read data valid
  input  wire                s_axi_rready,       // Read data ready
  output reg                 cpu_clk_en_o,       // Processor clock enable
  output reg                 periph_clk_en_o,    // Peripheral clock enable
  output reg                 flash_lowpwr_o,     // Flash low-power request
  output reg                 int_osc_en_o,       // Internal fast oscillator enable
  output reg                 ext_osc_en_o,       // External fast oscillator enable
  output reg                 pll_en_o,           // PLL enable
  output reg  [1:0]          sysclk_sel_o,       // System clock source
  output reg  [1:0]          regulator_mode_o,   // Regulator mode
  output reg                 sram_retain_o,      // SRAM retention in standby
  output reg                 backup_keep_o,      // Backup domain kept powered
  output reg                 sys_reset_n_o,      // Device reset, active low
  output reg                 monitor_irq_o,      // Supply monitor edge interrupt
  output reg                 clock_irq_o         // Clock failure interrupt
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_RUN     = 3'h0;
  localparam [2:0] ST_SLEEP   = 3'h1;
  localparam [2:0] ST_STOP    = 3'h2;
  localparam [2:0] ST_STBY    = 3'h3;
  localparam [2:0] ST_WAKE    = 3'h4;
  localparam [2:0] ST_RESET   = 3'h5;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam SYN_W = `EVT_W + 7;
  wire [SYN_W-1:0] raw_in = {event_lines_i, supply_ok_i, monitor_above_i,
                             external_reset_pin_n_i, watchdog_reset_i, wakeup_pin_i,
                             ext_clk_fail_i, int_osc_ready_i};
  reg  [SYN_W-1:0] sync1_q;
  reg  [SYN_W-1:0] sync2_q;

  // Supply-good is not gated by rst_n, so the first stage still tracks it
  always @(posedge sys_clk_i)
  begin
    sync1_q <= raw_in;
    sync2_q <= sync1_q;
  end

  wire [`EVT_W-1:0] evt_s   = sync2_q[SYN_W-1:7];
  wire supply_ok_s          = sync2_q[6];
  wire mon_above_s          = sync2_q[5];
  wire pin_rst_s            = ~sync2_q[4];
  wire wdg_rst_s            = sync2_q[3];
  wire wakeup_pin_s               = sync2_q[2];
  wire clk_fail_s           = sync2_q[1];
  wire osc_rdy_s            = sync2_q[0];

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg  [`CTRL_W-1:0] ctrl_q;
  reg  [`CLK_W-1:0]  clk_q;
  reg                sb_flag_q;
  reg                rise_flag_q;
  reg                fall_flag_q;
  reg                clk_fail_flag_q;
  reg                mon_prev_q;
  reg                wakeup_pin_prev_q;
  reg  [2:0]         state_q;
  reg  [3:0]         osc_cnt_q;
  reg                aw_hold_q;
  reg                w_hold_q;
  reg  [3:0]         aw_addr_q;
  reg  [31:0]        w_data_q;
  reg  [3:0]         w_strb_q;

  wire core_rst   = ~rst_n_i | ~supply_ok_s;
  wire stop_wake  = (|evt_s) | pin_rst_s | wdg_rst_s;
  wire wakeup_pin_rise  = wakeup_pin_s & ~wakeup_pin_prev_q;
  // Standby ignores the monitor line: that circuit is unpowered
  wire stby_wake  = (|evt_s[`EVT_W-1:`EVT_W-16]) | (|evt_s[2:0]) | pin_rst_s
                    | wdg_rst_s | wakeup_pin_rise;

  // Standby wake reset: controls go back to reset values, but the
  // standby flag is kept so software can still read it afterwards
  wire wake_rst   = (state_q == ST_RESET);
  wire ctl_rst    = core_rst | wake_rst;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  function addr_ok;
    input [3:0] a;
    begin
      addr_ok = (a == `ADDR_CTRL) | (a == `ADDR_STATUS) | (a == `ADDR_CLK)
                | (a == `ADDR_CLKSTAT);
    end
  endfunction

  wire        wr_go   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire        wr_ctrl = wr_go & (aw_addr_q == `ADDR_CTRL) & w_strb_q[0];
  wire        wr_clk  = wr_go & (aw_addr_q == `ADDR_CLK) & w_strb_q[0];
  wire        wr_cst  = wr_go & (aw_addr_q == `ADDR_CLKSTAT) & w_strb_q[1];
  wire        wr_st   = wr_go & (aw_addr_q == `ADDR_STATUS) & w_strb_q[0];
  wire        sb_clr  = wr_ctrl & w_data_q[`CTRL_SB_CLEAR];

  always @(posedge sys_clk_i)
  begin
    if (core_rst)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_addr_q    <= 4'h0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr_q) ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (core_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
      case (s_axi_araddr)
        `ADDR_CTRL:    s_axi_rdata <= {24'h000000, ctrl_q};
        `ADDR_STATUS:  s_axi_rdata <= {28'h0000000, fall_flag_q, rise_flag_q,
                                       mon_above_s, sb_flag_q};
        `ADDR_CLK:     s_axi_rdata <= {26'h0000000, clk_q};
        `ADDR_CLKSTAT: s_axi_rdata <= {23'h000000, clk_fail_flag_q, 6'h00, sysclk_sel_o};
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Standby flag, kept across the wake reset
  // ----------------------------------------
  // Supply loss or a control write with CTRL_SB_CLEAR set clears it; the wake reset and rst_n do not
  always @(posedge sys_clk_i)
  begin
    if (~supply_ok_s)
      sb_flag_q <= 1'b0;
    else if (state_q == ST_STBY && stby_wake)
      sb_flag_q <= 1'b1;
    else if (sb_clr)
      sb_flag_q <= 1'b0;
  end

  // ----------------------------------------
  // Supply monitor edges
  // ----------------------------------------
  wire mon_en   = ctrl_q[`CTRL_MON_EN];
  wire mon_rise = mon_en & mon_above_s & ~mon_prev_q;
  wire mon_fall = mon_en & ~mon_above_s & mon_prev_q;

  // The standby wake reset clears the edge flags as well
  always @(posedge sys_clk_i)
  begin
    if (ctl_rst)
    begin
      mon_prev_q    <= 1'b0;
      wakeup_pin_prev_q   <= 1'b0;
      rise_flag_q   <= 1'b0;
      fall_flag_q   <= 1'b0;
      monitor_irq_o <= 1'b0;
    end
    else
    begin
      mon_prev_q  <= mon_above_s;
      wakeup_pin_prev_q <= wakeup_pin_s;
      // Set wins over a write-one-to-clear in the same cycle
      if (mon_rise & ctrl_q[`CTRL_RISE_EN])
        rise_flag_q <= 1'b1;
      else if (wr_st & w_data_q[`STAT_RISE_FLAG])
        rise_flag_q <= 1'b0;
      if (mon_fall & ctrl_q[`CTRL_FALL_EN])
        fall_flag_q <= 1'b1;
      else if (wr_st & w_data_q[`STAT_FALL_FLAG])
        fall_flag_q <= 1'b0;
      monitor_irq_o <= rise_flag_q | fall_flag_q;
    end
  end

  // ----------------------------------------
  // Mode sequencer and control registers
  // ----------------------------------------
  always @(posedge sys_clk_i)
  begin
    // Wake reset also lands here; the flag block stays untouched
    if (ctl_rst)
    begin
      state_q         <= ST_RUN;
      ctrl_q          <= {`CTRL_W{1'b0}};
      clk_q           <= {`CLK_W{1'b0}};
      clk_fail_flag_q <= 1'b0;
      osc_cnt_q       <= 4'h0;
      clock_irq_o     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= w_data_q[`CTRL_W-1:0] & ~({{(`CTRL_W-1){1'b0}}, 1'b1} << `CTRL_SB_CLEAR);
      if (wr_clk)
        clk_q <= w_data_q[`CLK_W-1:0];
      if (clk_q[`CLK_SAFE_EN] & clk_fail_s & (clk_q[`CLK_SEL_MSB:`CLK_SEL_LSB] != `SEL_INT))
      begin
        clk_q[`CLK_SEL_MSB:`CLK_SEL_LSB] <= `SEL_INT;
        clk_q[`CLK_EXT_ON]               <= 1'b0;
        clk_q[`CLK_PLL_ON]               <= 1'b0;
        clk_fail_flag_q                  <= 1'b1;
      end
      else if (wr_cst & w_data_q[`CLK_FAIL_FLAG])
        clk_fail_flag_q <= 1'b0;
      clock_irq_o <= clk_fail_flag_q & clk_q[`CLK_IRQ_EN];
      case (state_q)
        ST_RUN:
          if (sleep_req_i)
            state_q <= ~ctrl_q[`CTRL_DEEP] ? ST_SLEEP :
                       (ctrl_q[`CTRL_STANDBY] ? ST_STBY : ST_STOP);
        ST_SLEEP:
          if (irq_any_i | (|evt_s))
            state_q <= ST_RUN;
        ST_STOP:
          if (stop_wake)
          begin
            state_q   <= ST_WAKE;
            osc_cnt_q <= 4'h0;
            clk_q[`CLK_SEL_MSB:`CLK_SEL_LSB] <= `SEL_INT;
            clk_q[`CLK_EXT_ON]               <= 1'b0;
            clk_q[`CLK_PLL_ON]               <= 1'b0;
          end
        ST_STBY:
          if (stby_wake)
            state_q <= ST_RESET;
        ST_WAKE:
          // Hold the core until the oscillator has settled
          if (osc_rdy_s && osc_cnt_q == `OSC_START_CYC)
            state_q <= ST_RUN;
          else if (osc_cnt_q != `OSC_START_CYC)
            osc_cnt_q <= osc_cnt_q + 4'h1;
        ST_RESET:
          // Not reached: ctl_rst already returns the state to run
          state_q <= ST_RUN;
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Shared state decode
  // ----------------------------------------
  // Fast clocks stay off through stop and standby
  function fast_clk_ok;
    input [2:0] st;
    begin
      fast_clk_ok = (st != ST_STOP) && (st != ST_STBY);
    end
  endfunction

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (core_rst)
    begin
      cpu_clk_en_o     <= 1'b0;
      periph_clk_en_o  <= 1'b0;
      flash_lowpwr_o   <= 1'b0;
      int_osc_en_o     <= 1'b1;
      ext_osc_en_o     <= 1'b0;
      pll_en_o         <= 1'b0;
      sysclk_sel_o     <= `SEL_INT;
      regulator_mode_o <= `REG_ON;
      sram_retain_o    <= 1'b0;
      backup_keep_o    <= 1'b1;
      sys_reset_n_o    <= 1'b0;
    end
    else
    begin
      sys_reset_n_o    <= (state_q != ST_RESET) && (state_q != ST_STBY);
      cpu_clk_en_o     <= (state_q == ST_RUN);
      periph_clk_en_o  <= (state_q == ST_RUN) | (state_q == ST_SLEEP);
      flash_lowpwr_o   <= (state_q == ST_STOP);
      int_osc_en_o     <= fast_clk_ok(state_q);
      ext_osc_en_o     <= clk_q[`CLK_EXT_ON] & fast_clk_ok(state_q);
      pll_en_o         <= clk_q[`CLK_PLL_ON] & fast_clk_ok(state_q);
      sysclk_sel_o     <= clk_q[`CLK_SEL_MSB:`CLK_SEL_LSB];
      backup_keep_o    <= 1'b1;
      sram_retain_o    <= (state_q == ST_STBY) & ctrl_q[`CTRL_RETAIN];
      case (state_q)
        ST_STOP:
          regulator_mode_o <= ctrl_q[`CTRL_LPREG] ? `REG_LOWPWR : `REG_ON;
        ST_STBY:
          regulator_mode_o <= `REG_SHUTDOWN;
        default:
          regulator_mode_o <= `REG_ON;
      endcase
    end
  end

endmodule // low_power_mode_controller

// ==== src/lpm_ctrl_defines.vh ====
// Purpose: Constants for the low-power mode controller
// Assumes: AXI4-Lite register map, 32-bit data, word aligned
// Notes:   Offsets and field positions are this block's own choice
`ifndef LPM_CTRL_DEFINES_VH
`define LPM_CTRL_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h4
`define ADDR_CLK         4'h8
`define ADDR_CLKSTAT     4'hc

// ----------------------------------------
// power_control_reg fields
// ----------------------------------------
`define CTRL_LPREG       0
`define CTRL_STANDBY     1
`define CTRL_SB_CLEAR    2
`define CTRL_MON_EN      3
`define CTRL_RISE_EN     4
`define CTRL_FALL_EN     5
`define CTRL_RETAIN      6
`define CTRL_DEEP        7
`define CTRL_W           8

// ----------------------------------------
// power_status_reg fields
// ----------------------------------------
`define STAT_SB_FLAG     0
`define STAT_MON_OUT     1
`define STAT_RISE_FLAG   2
`define STAT_FALL_FLAG   3

// ----------------------------------------
// Clock control fields
// ----------------------------------------
`define CLK_SEL_LSB      0
`define CLK_SEL_MSB      1
`define CLK_SAFE_EN      2
`define CLK_IRQ_EN       3
`define CLK_EXT_ON       4
`define CLK_PLL_ON       5
`define CLK_FAIL_FLAG    8
`define CLK_W            6

// ----------------------------------------
// Clock selections, regulator modes, widths, bus responses, start-up count
// ----------------------------------------
`define SEL_INT          2'h0
`define SEL_EXT          2'h1
`define SEL_PLL          2'h2
`define REG_ON           2'h0
`define REG_LOWPWR       2'h1
`define REG_SHUTDOWN     2'h2
`define EVT_W            20
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`define OSC_START_CYC    4'h8

`endif

// ==== tb/lpm_ctrl_properties.sv ====
// Purpose: Port-level assertions for the low-power mode controller
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound onto the controller; watches ports only
`include "lpm_ctrl_defines.vh"
module lpm_ctrl_properties (
  input wire       sys_clk_i,        // Clock
  input wire       rst_n_i,          // Reset, active low
  input wire       irq_any_i,        // Pending interrupt
  input wire       s_axi_bvalid,     // Write resp valid
  input wire       s_axi_bready,     // Write resp ready
  input wire [1:0] s_axi_bresp,      // Write resp
  input wire       s_axi_rvalid,     // Read valid
  input wire       s_axi_rready,     // Read ready
  input wire       cpu_clk_en_o,     // Core clock
  input wire       periph_clk_en_o,  // Peripheral clock
  input wire       flash_lowpwr_o,   // Flash low power
  input wire       int_osc_en_o,     // Internal osc
  input wire       ext_osc_en_o,     // External osc
  input wire       pll_en_o,         // PLL
  input wire [1:0] sysclk_sel_o,     // Clock source
  input wire [1:0] regulator_mode_o, // Regulator
  input wire       backup_keep_o,    // Backup kept
  input wire       sys_reset_n_o,    // Device reset
  input wire       monitor_irq_o,    // Monitor irq
  input wire       clock_irq_o       // Clock irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Mode, sequencing and bus handshake relations
  // ----------------------------------------
  chk_stop_osc_off: assert property (
    flash_lowpwr_o |-> !ext_osc_en_o && !pll_en_o) else $error("fast clock on in stop");
  chk_lp_only_stop: assert property (
    regulator_mode_o == `REG_LOWPWR |-> flash_lowpwr_o && !cpu_clk_en_o)
    else $error("low-power regulator outside stop");
  chk_clk_after_reg: assert property (
    $rose(cpu_clk_en_o) |-> regulator_mode_o == `REG_ON && int_osc_en_o)
    else $error("core clock before regulator");
  chk_shutdown_off: assert property (
    regulator_mode_o == `REG_SHUTDOWN |-> !cpu_clk_en_o && !periph_clk_en_o && backup_keep_o)
    else $error("logic alive in shutdown");
  chk_reset_exit: assert property (
    $rose(sys_reset_n_o) |-> regulator_mode_o == `REG_ON && sysclk_sel_o == `SEL_INT
    && !monitor_irq_o && !clock_irq_o) else $error("bad state after reset");
  chk_fail_irq: assert property (
    $rose(clock_irq_o) |-> sysclk_sel_o == `SEL_INT && !ext_osc_en_o && !pll_en_o)
    else $error("clock irq without fallback");
  chk_sleep_exit: assert property (
    !cpu_clk_en_o && periph_clk_en_o && !flash_lowpwr_o && sys_reset_n_o && irq_any_i
    |-> ##[1:3] cpu_clk_en_o) else $error("sleep not left on interrupt");
  chk_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_b_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
  chk_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("read data dropped");
endmodule // lpm_ctrl_properties

bind low_power_mode_controller lpm_ctrl_properties u_props (
  .sys_clk_i, .rst_n_i, .irq_any_i, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .cpu_clk_en_o, .periph_clk_en_o, .flash_lowpwr_o,
  .int_osc_en_o, .ext_osc_en_o, .pll_en_o, .sysclk_sel_o, .regulator_mode_o,
  .backup_keep_o, .sys_reset_n_o, .monitor_irq_o, .clock_irq_o);

// ==== tb/osc_ready_model.sv ====
// Purpose: Internal oscillator start-up model
// Assumes: Ready follows enable after a settling time
// Notes:   slow_i stretches start-up to test the wake wait
module osc_ready_model (
  input  wire  sys_clk_i,       // Clock
  input  wire  int_osc_en_i,    // Enable from controller
  input  wire  slow_i,          // Long start-up
  output logic int_osc_ready_o  // Stable flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q = 5'h0;
  always @(posedge sys_clk_i)
  begin
    if (!int_osc_en_i)
      cnt_q <= 5'h0; // Clears to zero when disabled
    else if (cnt_q != 5'h1f)
      cnt_q <= cnt_q + 5'h1;
  end
  // Never ready straight after a restart
  assign int_osc_ready_o = int_osc_en_i && (cnt_q >= (slow_i ? 5'h14 : 5'h02));
endmodule // osc_ready_model

// ==== tb/test_low_power_mode_controller.sv ====
// Purpose: Self-checking bench for the low-power mode controller
// Assumes: 100 MHz clock; wake sources driven as levels
// Notes:   Random values from an LFSR seeded with 99
`include "lpm_ctrl_defines.vh"
`define CHECK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAITC(c) for (int n = 0; n < 100 && !(c); n++) @(posedge sys_clk_i);
module test_low_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, rst_n_i = 0, supply_ok_i = 0, monitor_above_i = 1;
  logic sleep_req_i = 0, irq_any_i = 0, external_reset_pin_n_i = 1, slow = 0;
  logic watchdog_reset_i = 0, wakeup_pin_i = 0, ext_clk_fail_i = 0;
  logic [19:0] event_lines_i = 20'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, rd, wv;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] rsp;
  logic [15:0] rnd = 16'd99;
  wire int_osc_ready_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, cpu_clk_en_o, periph_clk_en_o, flash_lowpwr_o, int_osc_en_o;
  wire ext_osc_en_o, pll_en_o, sram_retain_o, backup_keep_o, sys_reset_n_o;
  wire monitor_irq_o, clock_irq_o;
  wire [1:0] s_axi_bresp, s_axi_rresp, sysclk_sel_o, regulator_mode_o;
  wire [31:0] s_axi_rdata;
  int err_total = 0, total_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  low_power_mode_controller dut (.sys_clk_i, .rst_n_i, .supply_ok_i, .monitor_above_i,
    .sleep_req_i, .irq_any_i, .event_lines_i, .external_reset_pin_n_i, .watchdog_reset_i,
    .wakeup_pin_i, .ext_clk_fail_i, .int_osc_ready_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_clk_en_o,
    .periph_clk_en_o, .flash_lowpwr_o, .int_osc_en_o, .ext_osc_en_o, .pll_en_o,
    .sysclk_sel_o, .regulator_mode_o, .sram_retain_o, .backup_keep_o, .sys_reset_n_o,
    .monitor_irq_o, .clock_irq_o);
  osc_ready_model u_osc (.sys_clk_i, .int_osc_en_i(int_osc_en_o), .slow_i(slow),
    .int_osc_ready_o(int_osc_ready_i));
  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function automatic [15:0] lfsr(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic [1:0] exp_reg(input lp);
    return lp ? `REG_LOWPWR : `REG_ON;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input [3:0] a, input [31:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    rnd = lfsr(rnd);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w))
    begin
      @(posedge sys_clk_i);
      aw |= s_axi_awvalid && s_axi_awready;
      w |= s_axi_wvalid && s_axi_wready;
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    // Late bready makes the slave hold its answer
    tick(rnd[1:0]);
    s_axi_bready <= 1;
    do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    tick(1);
  endtask
  task automatic rd_reg(input [3:0] a, output [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk_i); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 0;
    do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    tick(1);
  endtask
  task automatic req_sleep;
    sleep_req_i <= 1;
    tick(1);
    sleep_req_i <= 0;
    tick(2);
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    err_total++;
    end_of_test();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    tick(4);
    supply_ok_i <= 1;
    tick(4);
    rst_n_i <= 1;
    tick(2);
    `CHECK(regulator_mode_o, `REG_ON)
    `CHECK({sysclk_sel_o, int_osc_en_o, cpu_clk_en_o}, 4'b0011)
    rd_reg(4'h2, rd);
    `CHECK({rsp, rd}, {`AXI_SLVERR, 32'h0})
    wr(4'h6, 32'h0);
    `CHECK(rsp, `AXI_SLVERR)
    repeat (4)
    begin
      wv = {24'h0, rnd[7:0]} & 32'h7f;
      wr(`ADDR_CTRL, wv);
      rd_reg(`ADDR_CTRL, rd);
      `CHECK({rsp, rd}, {`AXI_OKAY, wv & 32'h7b})
    end
    wr(`ADDR_CTRL, 32'h18);
    monitor_above_i <= 0;
    tick(6);
    `CHECK(monitor_irq_o, 1'b0)
    for (int e = 1; e >= 0; e--)
    begin
      wr(`ADDR_CTRL, 32'h38);
      monitor_above_i <= e[0];
      `WAITC(monitor_irq_o === 1'b1)
      rd_reg(`ADDR_STATUS, rd);
      `CHECK({monitor_irq_o, rd[3:2]}, e ? 3'b101 : 3'b110)
      wr(`ADDR_STATUS, 32'hc);
      tick(2);
      `CHECK(monitor_irq_o, 1'b0)
      monitor_above_i <= 1;
      tick(4);
    end
    wr(`ADDR_CTRL, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      req_sleep();
      `CHECK({cpu_clk_en_o, periph_clk_en_o, flash_lowpwr_o}, 3'b010)
      if (k == 0) irq_any_i <= 1;
      else event_lines_i <= 20'h1 << (rnd % 20);
      `WAITC(cpu_clk_en_o === 1'b1)
      `CHECK(cpu_clk_en_o, 1'b1)
      irq_any_i <= 0;
      event_lines_i <= 20'h0;
      tick(4);
    end
    for (int k = 0; k < 3; k++)
    begin
      slow <= k[0];
      wr(`ADDR_CTRL, 32'h80 | k[0]);
      req_sleep();
      `CHECK({flash_lowpwr_o, ext_osc_en_o, pll_en_o, int_osc_en_o}, 4'b1000)
      `CHECK(regulator_mode_o, exp_reg(k[0]))
      if (k == 0) event_lines_i <= 20'h1 << (rnd % 20);
      else if (k == 1) watchdog_reset_i <= 1;
      else external_reset_pin_n_i <= 0;
      tick(4);
      event_lines_i <= 20'h0;
      watchdog_reset_i <= 0;
      external_reset_pin_n_i <= 1;
      `WAITC(cpu_clk_en_o === 1'b1)
      `CHECK({cpu_clk_en_o, regulator_mode_o, sysclk_sel_o}, 5'b10000)
      tick(4);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(`ADDR_CTRL, 32'hc2);
      req_sleep();
      `CHECK(regulator_mode_o, `REG_SHUTDOWN)
      `CHECK({cpu_clk_en_o, periph_clk_en_o}, 2'b00)
      `CHECK({backup_keep_o, sram_retain_o}, 2'b11)
      `CHECK(sys_reset_n_o, 1'b0)
      if (k == 0) wakeup_pin_i <= 1;
      else event_lines_i <= 20'h10 << (rnd % 16);
      `WAITC(cpu_clk_en_o === 1'b1)
      `CHECK({cpu_clk_en_o, sys_reset_n_o}, 2'b11)
      wakeup_pin_i <= 0;
      event_lines_i <= 20'h0;
      rd_reg(`ADDR_STATUS, rd);
      `CHECK(rd[0], 1'b1)
      rd_reg(`ADDR_CTRL, rd);
      `CHECK(rd, 32'h0)
      wr(`ADDR_CTRL, 32'h4);
      rd_reg(`ADDR_STATUS, rd);
      `CHECK(rd[0], 1'b0)
    end
    wr(`ADDR_CLK, 32'h1d);
    tick(2);
    `CHECK({sysclk_sel_o, ext_osc_en_o}, 3'b011)
    ext_clk_fail_i <= 1;
    `WAITC(clock_irq_o === 1'b1)
    `CHECK({clock_irq_o, sysclk_sel_o, ext_osc_en_o, pll_en_o}, 5'h10)
    rd_reg(`ADDR_CLKSTAT, rd);
    `CHECK(rd[8], 1'b1)
    ext_clk_fail_i <= 0;
    wr(`ADDR_CLKSTAT, 32'h100);
    tick(2);
    `CHECK(clock_irq_o, 1'b0)
    supply_ok_i <= 0;
    tick(4);
    `CHECK({sys_reset_n_o, cpu_clk_en_o, regulator_mode_o}, 4'h0)
    supply_ok_i <= 1;
    tick(5);
    `CHECK({sys_reset_n_o, cpu_clk_en_o, sysclk_sel_o}, 4'hc)
    end_of_test();
  end
endmodule // test_low_power_mode_controller
